// file: logic/tqd_regs.svh
`ifndef TQD_REGS_SVH
`define TQD_REGS_SVH
// ==========================================
// Register byte offsets
`define TQD_OFS_AXIS_EN 8'h00
`define TQD_OFS_IRQ_EN 8'h04
`define TQD_OFS_IRQ_CLR 8'h08
`define TQD_OFS_IRQ_STAT 8'h0C
`define TQD_OFS_AXIS0 8'h10
`define TQD_AXIS_STRIDE 8'h14
`define TQD_SUB_MODE 8'h00
`define TQD_SUB_QHIT 8'h04
`define TQD_SUB_IHIT 8'h08
`define TQD_SUB_QCNT 8'h0C
`define TQD_SUB_ICNT 8'h10
`define TQD_OFS_FILT 8'h4C
// ==========================================
// Field positions and writable masks
`define TQD_AXIS_EN_STRIDE 4
`define TQD_IRQ_AXIS_STRIDE 8
`define TQD_QIRQ_BIT 0
`define TQD_QMODE_BIT 2
`define TQD_IIRQ_BIT 4
`define TQD_IMODE_BIT 6
`define TQD_UNF_BIT 24
`define TQD_OVF_BIT 25
`define TQD_QMODE_LSB 0
`define TQD_IMODE_LSB 16
`define TQD_PRESC_LSB 0
`define TQD_FLEN_LSB 16
`define TQD_AXIS_EN_MASK 32'h0000_0111
`define TQD_IRQ_EN_MASK 32'h3F55_5555
`define TQD_FLAG_MASK 32'h3F11_1111
`define TQD_MODE_MASK 32'h0003_0003
`define TQD_FILT_MASK 32'h000F_FFFF
// ==========================================
// Reset values and timing
`define TQD_RST_ZERO 32'h0000_0000
`define TQD_CLK_NS 20
`define TQD_SAMPLE_NS 1000
`define TQD_PRESC_RST ((`TQD_SAMPLE_NS / `TQD_CLK_NS) - 1)
`define TQD_FLEN_RST 3
`define TQD_FILT_RST ((`TQD_FLEN_RST << `TQD_FLEN_LSB) | `TQD_PRESC_RST)
`define TQD_RESP_OKAY 2'h0
`define TQD_RESP_SLVERR 2'h2
`endif

// file: logic/tqd_pkg.sv
package tqd_pkg;
   // ==========================================
   // Counting resolution codes
   typedef enum logic [1:0] {
      QM_OFF = 2'h0,
      QM_X1 = 2'h1,
      QM_X2 = 2'h2,
      QM_X4 = 2'h3
   } tqd_qmode_e;
   // What the index counter counts
   typedef enum logic [1:0] {
      IM_HIGH = 2'h0,
      IM_RISE = 2'h1,
      IM_FALL = 2'h2,
      IM_BOTH = 2'h3
   } tqd_imode_e;
   // Settings of one axis
   typedef struct packed {
      logic enable;
      tqd_qmode_e qmode;
      tqd_imode_e imode;
      logic q_on_hit;
      logic i_on_hit;
      logic [31:0] qhit;
      logic [31:0] ihit;
   } tqd_axis_cfg_s;
   // One-cycle events of one axis
   typedef struct packed {
      logic q_evt;
      logic i_evt;
      logic ovf;
      logic unf;
   } tqd_axis_evt_s;
endpackage

// file: logic/tqd_top.sv
// How it works
// - Three axes, each position and index counter
// - Per axis count 1x, 2x or 4x
// - Inputs debounced; counts readable by software
// - Sample period and filter length programmable
// - Axis enables at bits 0, 4, 8
// - Overflow interrupt enables at 25, 27, 29
// - Underflow interrupt enables at 24, 26, 28
// - Index irq mode: change or compare equal
// - Position irq mode: change or compare equal
// - Index irq enables at 4, 12, 20
// - Position irq enables at 0, 8, 16
// - Clear register writes clear pending flags
// - Index mode: high, rise, fall, both
// - Position mode codes 01, 10, 11
// - 32-bit compare values; counters read-only
// - Status register mirrors enable layout
//
// The implementer's own choice: the AXI4-Lite slave port.
`include "tqd_regs.svh"
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// One axis: synchronise, debounce, decode, count
module tqd_axis (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Sampling
   input wire logic i_tick,
   input wire logic [3:0] i_filt_len,
   // Raw pins
   input wire logic i_pin_a,
   input wire logic i_pin_b,
   input wire logic i_pin_i,
   // Settings and results
   input wire tqd_pkg::tqd_axis_cfg_s i_cfg,
   output tqd_pkg::tqd_axis_evt_s o_evt,
   output logic [31:0] o_qcnt,
   output logic [31:0] o_icnt
);
   logic [2:0] sync1; // First stage, read only by sync2
   logic [2:0] sync2; // Safe copy of {a, b, index}
   logic [2:0] filt; // Debounced levels
   logic [2:0] next_filt;
   logic [2:0] last; // Debounced levels one cycle ago
   logic [3:0] run [3]; // Consecutive differing samples
   logic [3:0] next_run [3];
   logic [31:0] qcnt;
   logic [31:0] next_qcnt;
   logic [31:0] icnt;
   logic [31:0] next_icnt;
   logic ch_a;
   logic ch_b;
   logic legal;
   logic up;
   logic q_step;
   logic i_step;

   // Two flip-flops before any logic sees a pin
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end else begin
         sync1 <= {i_pin_a, i_pin_b, i_pin_i};
         sync2 <= sync1;
      end
   end

   // Debounce: a new level is taken after filt_len+1 differing samples
   always_comb begin
      next_filt = filt;
      next_run = run;
      for (int k = 0; k < 3; k++) begin
         if (i_tick) begin
            if (sync2[k] == filt[k]) begin
               next_run[k] = 4'h0; // Glitch ended, start over
            end else if (run[k] >= i_filt_len) begin
               next_filt[k] = sync2[k];
               next_run[k] = 4'h0;
            end else begin
               next_run[k] = run[k] + 4'h1;
            end
         end
      end
   end

   // Quadrature and index decode on debounced levels
   always_comb begin
      ch_a = filt[2] ^ last[2];
      ch_b = filt[1] ^ last[1];
      legal = ch_a ^ ch_b; // Both phases moving at once is dropped
      up = filt[2] ^ last[1]; // A leading B counts up
      case (i_cfg.qmode)
         tqd_pkg::QM_X1: begin
            q_step = legal && ch_a && (up ? filt[2] : !filt[2]);
         end
         tqd_pkg::QM_X2: begin
            q_step = legal && ch_a;
         end
         tqd_pkg::QM_X4: begin
            q_step = legal;
         end
         default: begin
            q_step = 1'b0;
         end
      endcase
      q_step = q_step && i_cfg.enable;
      case (i_cfg.imode)
         tqd_pkg::IM_HIGH: begin
            i_step = i_tick && filt[0];
         end
         tqd_pkg::IM_RISE: begin
            i_step = filt[0] && !last[0];
         end
         tqd_pkg::IM_FALL: begin
            i_step = !filt[0] && last[0];
         end
         default: begin
            i_step = filt[0] ^ last[0];
         end
      endcase
      i_step = i_step && i_cfg.enable;
      next_qcnt = qcnt;
      if (q_step) begin
         next_qcnt = up ? qcnt + 32'h1 : qcnt - 32'h1;
      end
      next_icnt = i_step ? icnt + 32'h1 : icnt;
      o_evt.ovf = q_step && up && (qcnt == 32'hFFFF_FFFF);
      o_evt.unf = q_step && !up && (qcnt == 32'h0);
      o_evt.q_evt = q_step && (!i_cfg.q_on_hit || next_qcnt == i_cfg.qhit);
      o_evt.i_evt = i_step && (!i_cfg.i_on_hit || next_icnt == i_cfg.ihit);
   end

   // Register filter and counter state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         filt <= 3'h0;
         last <= 3'h0;
         run <= '{default: 4'h0};
         qcnt <= 32'h0;
         icnt <= 32'h0;
      end else begin
         filt <= next_filt;
         last <= filt;
         run <= next_run;
         qcnt <= next_qcnt;
         icnt <= next_icnt;
      end
   end

   assign o_qcnt = qcnt;
   assign o_icnt = icnt;
endmodule

// ==========================================
// Three-axis decoder with AXI4-Lite registers
module tqd_top (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   // AXI4-Lite write
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // AXI4-Lite read
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // Encoder pins, bit 0 x, 1 y, 2 z
   input wire logic [2:0] I_PHASE_A,
   input wire logic [2:0] I_PHASE_B,
   input wire logic [2:0] I_INDEX,
   // Interrupt
   output logic O_IRQ
);
   logic [31:0] axis_en, next_axis_en;
   logic [31:0] irq_en, next_irq_en;
   logic [31:0] flags, next_flags; // Pending sources, status layout
   logic [31:0] filt_cfg, next_filt_cfg;
   logic [31:0] mode_r [3];
   logic [31:0] next_mode [3];
   logic [31:0] qhit [3];
   logic [31:0] next_qhit [3];
   logic [31:0] ihit [3];
   logic [31:0] next_ihit [3];
   logic [15:0] presc, next_presc;
   logic tick, next_tick;
   logic irq, next_irq;
   // Bus slave state
   logic aw_full, next_aw_full;
   logic w_full, next_w_full;
   logic [7:0] waddr, next_waddr;
   logic [31:0] wdata, next_wdata;
   logic [3:0] wstrb, next_wstrb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [31:0] rdata, next_rdata;
   logic [1:0] rresp, next_rresp;
   logic awready, wready, arready; // Readies kept in flops so every output leaves a register
   // Per-axis wiring
   tqd_pkg::tqd_axis_cfg_s cfg [3];
   tqd_pkg::tqd_axis_evt_s evt [3];
   logic [31:0] qcnt [3];
   logic [31:0] icnt [3];
   logic [31:0] wmask;
   logic [31:0] clr;
   logic [31:0] set;
   logic [7:0] base;
   logic do_wr;
   logic hit;

   // Sample tick; period is presc+1 clocks
   always_comb begin
      next_tick = 1'b0;
      next_presc = presc + 16'h1;
      if (presc >= filt_cfg[`TQD_PRESC_LSB +: 16]) begin
         next_presc = 16'h0;
         next_tick = 1'b1;
      end
   end

   // ==========================================
   // Axes
   for (genvar a = 0; a < 3; a++) begin : g_axis
      // Gather settings of this axis from the registers
      always_comb begin
         cfg[a].enable = axis_en[a * `TQD_AXIS_EN_STRIDE];
         cfg[a].qmode = tqd_pkg::tqd_qmode_e'(mode_r[a][`TQD_QMODE_LSB +: 2]);
         cfg[a].imode = tqd_pkg::tqd_imode_e'(mode_r[a][`TQD_IMODE_LSB +: 2]);
         cfg[a].q_on_hit = irq_en[a * `TQD_IRQ_AXIS_STRIDE + `TQD_QMODE_BIT];
         cfg[a].i_on_hit = irq_en[a * `TQD_IRQ_AXIS_STRIDE + `TQD_IMODE_BIT];
         cfg[a].qhit = qhit[a];
         cfg[a].ihit = ihit[a];
      end
      tqd_axis u_axis (
         .i_clk(I_MCLK),
         .i_rst_n(I_RST_N),
         .i_tick(tick),
         .i_filt_len(filt_cfg[`TQD_FLEN_LSB +: 4]),
         .i_pin_a(I_PHASE_A[a]),
         .i_pin_b(I_PHASE_B[a]),
         .i_pin_i(I_INDEX[a]),
         .i_cfg(cfg[a]),
         .o_evt(evt[a]),
         .o_qcnt(qcnt[a]),
         .o_icnt(icnt[a])
      );
   end

   // ==========================================
   // Write side: address and data taken in either order
   always_comb begin
      next_aw_full = aw_full;
      next_w_full = w_full;
      next_waddr = waddr;
      next_wdata = wdata;
      next_wstrb = wstrb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_axis_en = axis_en;
      next_irq_en = irq_en;
      next_filt_cfg = filt_cfg;
      next_mode = mode_r;
      next_qhit = qhit;
      next_ihit = ihit;
      clr = 32'h0;
      hit = 1'b0;
      base = 8'h0;
      wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      do_wr = aw_full && w_full && !bvalid;
      if (I_AWVALID && !aw_full) begin
         next_aw_full = 1'b1;
         next_waddr = I_AWADDR;
      end
      if (I_WVALID && !w_full) begin
         next_w_full = 1'b1;
         next_wdata = I_WDATA;
         next_wstrb = I_WSTRB;
      end
      if (bvalid && I_BREADY) begin
         next_bvalid = 1'b0;
      end
      if (do_wr) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         hit = 1'b1;
         case (waddr)
            `TQD_OFS_AXIS_EN: begin
               next_axis_en = ((axis_en & ~wmask) | (wdata & wmask)) & `TQD_AXIS_EN_MASK;
            end
            `TQD_OFS_IRQ_EN: begin
               next_irq_en = ((irq_en & ~wmask) | (wdata & wmask)) & `TQD_IRQ_EN_MASK;
            end
            `TQD_OFS_IRQ_CLR: begin
               clr = wdata & wmask & `TQD_FLAG_MASK;
            end
            `TQD_OFS_IRQ_STAT: begin
               hit = 1'b1; // Read-only, write ignored
            end
            `TQD_OFS_FILT: begin
               next_filt_cfg = ((filt_cfg & ~wmask) | (wdata & wmask)) & `TQD_FILT_MASK;
            end
            default: begin
               hit = 1'b0;
               for (int a = 0; a < 3; a++) begin
                  base = `TQD_OFS_AXIS0 + 8'(a) * `TQD_AXIS_STRIDE;
                  if (waddr == base + `TQD_SUB_MODE) begin
                     next_mode[a] = ((mode_r[a] & ~wmask) | (wdata & wmask)) & `TQD_MODE_MASK;
                     hit = 1'b1;
                  end
                  if (waddr == base + `TQD_SUB_QHIT) begin
                     next_qhit[a] = (qhit[a] & ~wmask) | (wdata & wmask);
                     hit = 1'b1;
                  end
                  if (waddr == base + `TQD_SUB_IHIT) begin
                     next_ihit[a] = (ihit[a] & ~wmask) | (wdata & wmask);
                     hit = 1'b1;
                  end
                  if (waddr == base + `TQD_SUB_QCNT || waddr == base + `TQD_SUB_ICNT) begin
                     hit = 1'b1; // Counters are read-only
                  end
               end
            end
         endcase
         next_bresp = hit ? `TQD_RESP_OKAY : `TQD_RESP_SLVERR;
      end
   end

   // Sticky flags; a new event beats a clear in the same cycle
   always_comb begin
      set = 32'h0;
      for (int a = 0; a < 3; a++) begin
         set[a * `TQD_IRQ_AXIS_STRIDE + `TQD_QIRQ_BIT] = evt[a].q_evt;
         set[a * `TQD_IRQ_AXIS_STRIDE + `TQD_IIRQ_BIT] = evt[a].i_evt;
         set[`TQD_OVF_BIT + 2 * a] = evt[a].ovf;
         set[`TQD_UNF_BIT + 2 * a] = evt[a].unf;
      end
      next_flags = (flags & ~clr) | set;
      // Enable bits sit where their flags sit, so one AND gates all
      next_irq = |(next_flags & irq_en & `TQD_FLAG_MASK);
   end

   // ==========================================
   // Read side: one read at a time, data held until taken
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      if (rvalid && I_RREADY) begin
         next_rvalid = 1'b0;
      end
      if (I_ARVALID && !rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = `TQD_RESP_OKAY;
         next_rdata = 32'h0;
         case (I_ARADDR)
            `TQD_OFS_AXIS_EN: next_rdata = axis_en;
            `TQD_OFS_IRQ_EN: next_rdata = irq_en;
            `TQD_OFS_IRQ_CLR: next_rdata = 32'h0; // Write-to-clear, reads zero
            `TQD_OFS_IRQ_STAT: next_rdata = flags;
            `TQD_OFS_FILT: next_rdata = filt_cfg;
            default: begin
               next_rresp = `TQD_RESP_SLVERR;
               for (int a = 0; a < 3; a++) begin
                  if (I_ARADDR == `TQD_OFS_AXIS0 + 8'(a) * `TQD_AXIS_STRIDE + `TQD_SUB_MODE) begin
                     next_rdata = mode_r[a];
                     next_rresp = `TQD_RESP_OKAY;
                  end
                  if (I_ARADDR == `TQD_OFS_AXIS0 + 8'(a) * `TQD_AXIS_STRIDE + `TQD_SUB_QHIT) begin
                     next_rdata = qhit[a];
                     next_rresp = `TQD_RESP_OKAY;
                  end
                  if (I_ARADDR == `TQD_OFS_AXIS0 + 8'(a) * `TQD_AXIS_STRIDE + `TQD_SUB_IHIT) begin
                     next_rdata = ihit[a];
                     next_rresp = `TQD_RESP_OKAY;
                  end
                  if (I_ARADDR == `TQD_OFS_AXIS0 + 8'(a) * `TQD_AXIS_STRIDE + `TQD_SUB_QCNT) begin
                     next_rdata = qcnt[a];
                     next_rresp = `TQD_RESP_OKAY;
                  end
                  if (I_ARADDR == `TQD_OFS_AXIS0 + 8'(a) * `TQD_AXIS_STRIDE + `TQD_SUB_ICNT) begin
                     next_rdata = icnt[a];
                     next_rresp = `TQD_RESP_OKAY;
                  end
               end
            end
         endcase
      end
   end

   // Register everything; outputs come straight from these
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         axis_en <= `TQD_RST_ZERO;
         irq_en <= `TQD_RST_ZERO;
         flags <= `TQD_RST_ZERO;
         filt_cfg <= `TQD_FILT_RST;
         mode_r <= '{default: `TQD_RST_ZERO};
         qhit <= '{default: `TQD_RST_ZERO};
         ihit <= '{default: `TQD_RST_ZERO};
         presc <= 16'h0;
         tick <= 1'b0;
         irq <= 1'b0;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         waddr <= 8'h0;
         wdata <= 32'h0;
         wstrb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= 2'h0;
         awready <= 1'b1;
         wready <= 1'b1;
         arready <= 1'b1;
      end else begin
         axis_en <= next_axis_en;
         irq_en <= next_irq_en;
         flags <= next_flags;
         filt_cfg <= next_filt_cfg;
         mode_r <= next_mode;
         qhit <= next_qhit;
         ihit <= next_ihit;
         presc <= next_presc;
         tick <= next_tick;
         irq <= next_irq;
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         waddr <= next_waddr;
         wdata <= next_wdata;
         wstrb <= next_wstrb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
         awready <= !next_aw_full;
         wready <= !next_w_full;
         arready <= !next_rvalid;
      end
   end

   // Ready means the holding slot is empty
   assign O_AWREADY = awready;
   assign O_WREADY = wready;
   assign O_ARREADY = arready;
   assign O_BVALID = bvalid;
   assign O_BRESP = bresp;
   assign O_RVALID = rvalid;
   assign O_RDATA = rdata;
   assign O_RRESP = rresp;
   assign O_IRQ = irq;
endmodule
`default_nettype wire

// file: verification/tqd_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port-level checks on the register bus and interrupt
module tqd_assertions (
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST_N,
   // Write side
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic [1:0] O_BRESP,
   input wire logic O_BVALID,
   input wire logic I_BREADY,
   // Read side
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0] O_RRESP,
   input wire logic O_RVALID,
   input wire logic I_RREADY,
   // Interrupt
   input wire logic O_IRQ
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RST_N);
   // ==========================================
   // Responses stand until taken
   a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
   a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
      else $error("read data dropped early");
   // Answer timing from the hand-over figures
   a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
      else $error("read answer late");
   a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
      |-> ##[1:2] O_BVALID)
      else $error("write answer late");
   // A full slot refuses new requests
   a_read_busy: assert property (O_RVALID |-> !O_ARREADY)
      else $error("read accepted while busy");
   a_write_busy: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
      |=> !O_AWREADY && !O_WREADY)
      else $error("write accepted while busy");
   a_write_release: assert property (O_BVALID && I_BREADY
      |=> !O_BVALID && O_AWREADY && O_WREADY)
      else $error("write slot not freed");
   // Error reads carry zero, codes are OKAY or SLVERR only
   a_resp_code: assert property (O_RVALID |-> O_RRESP inside {2'h0, 2'h2})
      else $error("bad read response code");
   a_unmapped_zero: assert property (O_RVALID && O_RRESP == 2'h2 |-> O_RDATA == 32'h0)
      else $error("error read carries data");
   // Reset clears every enable, so no interrupt at release
   a_irq_reset: assert property ($rose(I_RST_N) |-> !O_IRQ)
      else $error("interrupt after reset");
endmodule
bind tqd_top tqd_assertions chk (.I_MCLK, .I_RST_N, .I_AWVALID, .O_AWREADY, .I_WVALID,
   .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP,
   .O_RVALID, .I_RREADY, .O_IRQ);
`default_nettype wire

// file: verification/tqd_enc_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Encoder sensors: two phases and an index line per axis
module tqd_enc_model (
   // Pins toward the decoder, bit 0 x, 1 y, 2 z
   output var logic [2:0] o_a,
   output var logic [2:0] o_b,
   output var logic [2:0] o_i
);
   // Gray position of each axis, 0 to 3
   logic [1:0] pos [3];
   initial begin
      o_a = 3'h0;
      o_b = 3'h0;
      o_i = 3'h0;
      pos = '{default: 2'h0};
   end
   // One step; forward lets phase A lead phase B
   task automatic step(input int ax, input bit fwd);
      logic [1:0] p;
      p = fwd ? pos[ax] + 2'h1 : pos[ax] - 2'h1;
      pos[ax] = p;
      o_a[ax] <= p[1] ^ p[0];
      o_b[ax] <= p[1];
   endtask
   // Both phases at once: a fault the decoder must ignore
   task automatic dbl(input int ax);
      pos[ax] = pos[ax] + 2'h2;
      o_a[ax] <= ~o_a[ax];
      o_b[ax] <= ~o_b[ax];
   endtask
   // Index line level
   task automatic idx(input int ax, input logic v);
      o_i[ax] <= v;
   endtask
endmodule
`default_nettype wire

// file: verification/tqd_top_test.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Register-level bench for the three-axis decoder
module tqd_top_test;
   // Bus drive, held between edges
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   // Design answers
   wire logic awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [2:0] pa, pb, pi;
   // Tallies and expectations
   int num_errors = 0, total_checks = 0;
   logic [31:0] exp_q [3], exp_i, got;
   logic [1:0] resp;

   // Half period of 10 ns gives 50 MHz
   always #10 clk = ~clk;

   tqd_enc_model enc (.o_a(pa), .o_b(pb), .o_i(pi));
   tqd_top dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_PHASE_A(pa),
      .I_PHASE_B(pb), .I_INDEX(pi), .O_IRQ(irq));

   // ==========================================
   // Helpers
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      got = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(got, e);
   endtask
   // Filter shortened to one sample a clock, so ten clocks settle a step
   task automatic mv(input int ax, input bit fwd);
      @(posedge clk);
      enc.step(ax, fwd);
      wt(10);
   endtask
   task automatic pin_i(input logic v);
      @(posedge clk);
      enc.idx(0, v);
      wt(10);
   endtask
   function automatic logic [7:0] base(input int ax);
      return 8'(8'h10 + 8'h14 * ax);
   endfunction
   task automatic close_out;
      $display("Totals: %0d checks, %0d mismatches", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs well under 10000 clocks
   initial begin
      wt(40000);
      num_errors++;
      $display("MISMATCH %0t: watchdog expired", $time);
      close_out();
   end

   // ==========================================
   // Test sequence
   initial begin
      wt(16);
      rst_n <= 1'b1;
      rc(8'h00, 32'h0);
      rc(8'h04, 32'h0);
      rc(8'h0C, 32'h0);
      rc(8'h4C, 32'h0003_0031);
      rd(8'hF0);
      chk({30'h0, resp}, 32'h2);
      $display("test reset_values done");
      // Every resolution on every axis, four steps each
      wr(8'h4C, 32'h0);
      wr(8'h00, 32'h111);
      rc(8'h00, 32'h111);
      exp_q = '{default: 32'h0};
      for (int m = 1; m < 4; m++) begin
         for (int ax = 0; ax < 3; ax++) begin
            wr(base(ax), 32'(m));
            repeat (4) mv(ax, 1'b1);
            exp_q[ax] += 32'((m == 3) ? 4 : m);
            rc(8'(base(ax) + 8'h0C), exp_q[ax]);
         end
      end
      $display("test count_modes done");
      // Second reset mid-run; all pins are back at rest
      @(posedge clk);
      rst_n <= 1'b0;
      wt(4);
      rst_n <= 1'b1;
      wr(8'h4C, 32'h0);
      wr(8'h00, 32'h1);
      wr(8'h10, 32'h3);
      wr(8'h24, 32'h3);
      mv(1, 1'b1);
      rc(8'h30, 32'h0);
      wr(8'h04, 32'h0100_0000);
      mv(0, 1'b0);
      rc(8'h1C, 32'hFFFF_FFFF);
      rc(8'h0C, 32'h0100_0001);
      chk({31'h0, irq}, 32'h1);
      wr(8'h08, 32'h0100_0001);
      rc(8'h0C, 32'h0);
      chk({31'h0, irq}, 32'h0);
      mv(0, 1'b1);
      rc(8'h0C, 32'h0200_0001);
      chk({31'h0, irq}, 32'h0);
      wr(8'h04, 32'h0200_0000);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      wr(8'h08, 32'h0200_0001);
      // Both phases flipped together, twice, must not move the count
      @(posedge clk);
      enc.dbl(0);
      wt(10);
      @(posedge clk);
      enc.dbl(0);
      wt(10);
      rc(8'h1C, 32'h0);
      rc(8'h0C, 32'h0);
      $display("test wrap_flags done");
      // Position compare on y: flag only at equality
      wr(8'h00, 32'h111);
      wr(8'h04, 32'h0000_0500);
      wr(8'h28, 32'h2);
      mv(1, 1'b1);
      rc(8'h0C, 32'h0);
      mv(1, 1'b1);
      rc(8'h30, 32'h2);
      rc(8'h0C, 32'h100);
      chk({31'h0, irq}, 32'h1);
      wr(8'h30, 32'h5);
      chk({30'h0, resp}, 32'h0);
      rc(8'h30, 32'h2);
      wr(8'hF0, 32'h1);
      chk({30'h0, resp}, 32'h2);
      $display("test compare_ro done");
      // Index edge modes on x, one pulse each
      exp_i = 32'h0;
      for (int im = 1; im < 4; im++) begin
         wr(8'h10, 32'((im << 16) | 3));
         pin_i(1'b1);
         pin_i(1'b0);
         exp_i += 32'((im == 3) ? 2 : 1);
         rc(8'h20, exp_i);
      end
      rc(8'h0C, 32'h110);
      // Index compare: rising edge reaches the compare value
      wr(8'h04, 32'h0000_0050);
      wr(8'h18, exp_i + 32'h1);
      wr(8'h08, 32'h110);
      pin_i(1'b1);
      pin_i(1'b0);
      rc(8'h0C, 32'h10);
      chk({31'h0, irq}, 32'h1);
      // High-level mode: one count per tick while the filtered index is high
      wr(8'h10, 32'h3);
      pin_i(1'b1);
      pin_i(1'b0);
      rc(8'h20, 32'h0000_0011);
      $display("test index_modes done");
      close_out();
   end
endmodule
`default_nettype wire
